// file: mt_timer.sv
// modulo timer with axi4-lite register slave
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mt_timer (
    input  wire logic        aclk,                 // bus clock
    input  wire logic        aresetn,              // sync reset, low
    input  wire logic [7:0]  s_axi_awaddr,         // write address
    input  wire logic        s_axi_awvalid,        // write address valid
    output logic             s_axi_awready,        // write address ready
    input  wire logic [31:0] s_axi_wdata,          // write data
    input  wire logic [3:0]  s_axi_wstrb,          // byte enables
    input  wire logic        s_axi_wvalid,         // write data valid
    output logic             s_axi_wready,         // write data ready
    output logic [1:0]       s_axi_bresp,          // write response
    output logic             s_axi_bvalid,         // write response valid
    input  wire logic        s_axi_bready,         // write response ready
    input  wire logic [7:0]  s_axi_araddr,         // read address
    input  wire logic        s_axi_arvalid,        // read address valid
    output logic             s_axi_arready,        // read address ready
    output logic [31:0]      s_axi_rdata,          // read data
    output logic [1:0]       s_axi_rresp,          // read response
    output logic             s_axi_rvalid,         // read data valid
    input  wire logic        s_axi_rready,         // read data ready
    input  wire logic        ext_timer_clock_pin,  // external count clock
    input  wire logic        fixed_freq_clock,     // fixed clock level
    input  wire logic        wait_mode,            // cpu in wait
    input  wire logic        stop_mode,            // any stop mode
    input  wire logic        stop_deep_wake,       // deep stop wake pulse
    input  wire logic        debug_active,         // background debug
    output logic             irq                   // level interrupt
);
    // bus state
    logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    // timer state
    logic [7:0]  count_q, limit_q, pre_q, irq_stat_q, irq_mask_q;
    logic [1:0]  count_source_select_q;
    logic [3:0]  prescale_select_q;
    logic        counter_halt_bit_q, overflow_flag_q;
    logic        overflow_irq_enable_q, clr_arm_q, irq_q;
    logic        ext_s1_q, ext_s2_q, ext_s3_q, fix_s_q;
    // decoded strobes
    logic        wr_en, rd_en, wr_ctrl, wr_limit, wr_count, crst;
    logic        timer_rst, run, src_pulse, tick, wrap;
    logic [7:0]  wbyte, div_max, lim_eff;

    // timer state returns to reset on bus reset or deep stop wake
    assign timer_rst = !aresetn || stop_deep_wake;

    // write and read acceptance
    assign wr_en    = awready_q && s_axi_awvalid && s_axi_wvalid;
    assign rd_en    = arready_q && s_axi_arvalid;
    assign wbyte    = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
    assign wr_ctrl  = wr_en && s_axi_wstrb[0]
                      && (s_axi_awaddr == mt_pkg::OFS_CTRL);
    assign wr_limit = wr_en && s_axi_wstrb[0]
                      && (s_axi_awaddr == mt_pkg::OFS_LIMIT);
    assign wr_count = wr_en && s_axi_wstrb[0]
                      && (s_axi_awaddr == mt_pkg::OFS_COUNT);
    assign crst     = wr_ctrl && wbyte[mt_pkg::BIT_CRST];

    // write channel: take address and data together, then respond
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= mt_pkg::RESP_OKAY;
        end else begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            if (s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q) begin
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
            if (wr_en) begin
                bvalid_q <= 1'b1;
                case (s_axi_awaddr)
                    mt_pkg::OFS_CTRL, mt_pkg::OFS_CLKCFG, mt_pkg::OFS_COUNT,
                    mt_pkg::OFS_LIMIT, mt_pkg::OFS_IRQSTAT,
                    mt_pkg::OFS_IRQMASK: bresp_q <= mt_pkg::RESP_OKAY;
                    default:             bresp_q <= mt_pkg::RESP_SLVERR;
                endcase
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read channel: one-cycle ready pulse, data the cycle after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= mt_pkg::RESP_OKAY;
        end else begin
            arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
            if (rd_en) begin
                rvalid_q <= 1'b1;
                rresp_q  <= mt_pkg::RESP_OKAY;
                rdata_q  <= 32'h0000_0000;
                case (s_axi_araddr)
                    mt_pkg::OFS_CTRL: begin
                        // counter-reset bit always reads zero
                        rdata_q[7:0] <= {overflow_flag_q,
                                         overflow_irq_enable_q, 1'b0,
                                         counter_halt_bit_q, 4'h0};
                    end
                    mt_pkg::OFS_CLKCFG: begin
                        rdata_q[7:0] <= {2'h0, count_source_select_q,
                                         prescale_select_q};
                    end
                    mt_pkg::OFS_COUNT:   rdata_q[7:0] <= count_q;
                    mt_pkg::OFS_LIMIT:   rdata_q[7:0] <= limit_q;
                    mt_pkg::OFS_IRQSTAT: rdata_q[7:0] <= irq_stat_q;
                    mt_pkg::OFS_IRQMASK: rdata_q[7:0] <= irq_mask_q;
                    default:             rresp_q <= mt_pkg::RESP_SLVERR;
                endcase
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // control and configuration registers
    always_ff @(posedge aclk) begin
        if (timer_rst) begin
            counter_halt_bit_q    <= mt_pkg::RST_HALT;
            overflow_irq_enable_q <= 1'b0;
            count_source_select_q <= mt_pkg::RST_SRC;
            prescale_select_q     <= mt_pkg::RST_PS;
            limit_q               <= mt_pkg::RST_LIMIT;
            irq_mask_q            <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                counter_halt_bit_q    <= wbyte[mt_pkg::BIT_HALT];
                overflow_irq_enable_q <= wbyte[mt_pkg::BIT_OVFIE];
            end
            if (wr_en && s_axi_wstrb[0]
                && s_axi_awaddr == mt_pkg::OFS_CLKCFG) begin
                count_source_select_q <= wbyte[mt_pkg::SRC_LSB +: 2];
                prescale_select_q     <= wbyte[mt_pkg::PS_LSB +: 4];
            end
            if (wr_limit) begin
                limit_q <= wbyte;
            end
            if (wr_en && s_axi_wstrb[0]
                && s_axi_awaddr == mt_pkg::OFS_IRQMASK) begin
                irq_mask_q <= {7'h00, wbyte[0]};
            end
        end
    end

    // external pin synchroniser and fixed clock sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            fix_s_q  <= 1'b0;
        end else begin
            ext_s1_q <= ext_timer_clock_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            fix_s_q  <= fixed_freq_clock;
        end
    end

    // source edge select; pin edges assume pin at most half rate
    always_comb begin
        case (mt_pkg::mt_src_t'(count_source_select_q))
            mt_pkg::MT_SRC_BUS:   src_pulse = 1'b1;
            mt_pkg::MT_SRC_FIXED: src_pulse = fixed_freq_clock && !fix_s_q;
            mt_pkg::MT_SRC_EXT_F: src_pulse = !ext_s2_q && ext_s3_q;
            mt_pkg::MT_SRC_EXT_R: src_pulse = ext_s2_q && !ext_s3_q;
            default:              src_pulse = 1'b0;
        endcase
    end

    // run gate: wait mode keeps running, stop and debug hold
    assign run = !counter_halt_bit_q && !stop_mode
                 && !debug_active;

    // prescale terminal count, codes above eight divide by 256
    always_comb begin
        if (prescale_select_q >= mt_pkg::PS_MAX) begin
            div_max = 8'hFF;
        end else begin
            div_max = 8'((9'h001 << prescale_select_q) - 9'h001);
        end
    end

    assign tick    = run && src_pulse && (pre_q == div_max);
    assign lim_eff = (limit_q == 8'h00) ? 8'hFF : limit_q;
    assign wrap    = tick && (count_q == lim_eff);

    // prescaler, restarted with the counter except on a count write
    always_ff @(posedge aclk) begin
        if (timer_rst || crst || wr_limit) begin
            pre_q <= 8'h00;
        end else if (run && src_pulse) begin
            pre_q <= (pre_q == div_max) ? 8'h00 : pre_q + 8'h01;
        end
    end

    // main counter; stop-mode exit by interrupt keeps the value
    always_ff @(posedge aclk) begin
        if (timer_rst) begin
            count_q <= mt_pkg::RST_COUNT;
        end else if (crst || wr_limit || wr_count) begin
            count_q <= 8'h00;
        end else if (wrap) begin
            count_q <= 8'h00;
        end else if (tick) begin
            count_q <= count_q + 8'h01;
        end
    end

    // overflow flag with read-then-write-zero clearing, set wins
    always_ff @(posedge aclk) begin
        if (timer_rst) begin
            overflow_flag_q <= 1'b0;
            clr_arm_q       <= 1'b0;
        end else begin
            if (rd_en && s_axi_araddr == mt_pkg::OFS_CTRL
                && overflow_flag_q) begin
                clr_arm_q <= 1'b1;
            end else if (wr_ctrl) begin
                clr_arm_q <= 1'b0;
            end
            if (wrap) begin
                overflow_flag_q <= 1'b1;
            end else if (crst || wr_limit
                         || (wr_ctrl && clr_arm_q
                             && !wbyte[mt_pkg::BIT_OVF])) begin
                overflow_flag_q <= 1'b0;
            end
        end
    end

    // sticky event status, cleared by reading it, set wins
    always_ff @(posedge aclk) begin
        if (timer_rst) begin
            irq_stat_q <= 8'h00;
        end else if (wrap) begin
            irq_stat_q <= 8'h01;
        end else if (rd_en && s_axi_araddr == mt_pkg::OFS_IRQSTAT) begin
            irq_stat_q <= 8'h00;
        end
    end

    // registered interrupt, also a wait-mode wakeup
    always_ff @(posedge aclk) begin
        if (timer_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (overflow_flag_q && overflow_irq_enable_q)
                     || |(irq_stat_q & irq_mask_q);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign irq           = irq_q;

    // checks on the timer behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (timer_rst);

    property p_halt_hold;
        counter_halt_bit_q && !wr_en |=> $stable(count_q);
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("counter moved while halted");

    property p_crst_zero;
        crst |=> (count_q == 8'h00) && (pre_q == 8'h00);
    endproperty
    a_crst_zero: assert property (p_crst_zero)
        else $error("counter reset did not zero counter");

    property p_wrap_flag;
        wrap |=> overflow_flag_q && (count_q == 8'h00);
    endproperty
    a_wrap_flag: assert property (p_wrap_flag)
        else $error("wrap did not set flag");

    property p_irq_flag;
        overflow_flag_q && overflow_irq_enable_q |=> irq_q;
    endproperty
    a_irq_flag: assert property (p_irq_flag)
        else $error("interrupt missing with flag and enable");

    property p_stop_hold;
        stop_mode && !wr_en |-> !tick ##1 $stable(count_q);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("counter moved in stop mode");

    property p_dbg_hold;
        debug_active && !wr_en |=> $stable(count_q);
    endproperty
    a_dbg_hold: assert property (p_dbg_hold)
        else $error("counter moved in debug mode");

    property p_reset_vals;
        disable iff (1'b0) timer_rst |=> counter_halt_bit_q
            && !overflow_irq_enable_q && count_q == 8'h00 && !irq_q;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    property p_step;
        tick && !wrap && !wr_en |=> count_q == $past(count_q) + 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("counter did not step by one");

    property p_bus_div;
        run && count_source_select_q == 2'h0 && prescale_select_q == 4'h1
        && pre_q == 8'h00 && !wr_en |=> pre_q == 8'h01 && (tick || !run);
    endproperty
    a_bus_div: assert property (p_bus_div)
        else $error("divide by two tick missing");

    c_wrap: cover property (wrap && limit_q != 8'h00);
    c_irq:  cover property ($rose(irq_q));
    c_ext:  cover property (tick && count_source_select_q[1]);
endmodule : mt_timer

// file: mt_pkg.sv
// constants for the modulo timer block
package mt_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CLKCFG  = 8'h04;
    localparam logic [7:0] OFS_COUNT   = 8'h08;
    localparam logic [7:0] OFS_LIMIT   = 8'h0C;
    localparam logic [7:0] OFS_IRQSTAT = 8'h10;
    localparam logic [7:0] OFS_IRQMASK = 8'h14;

    // control register fields
    localparam int BIT_OVF   = 7;
    localparam int BIT_OVFIE = 6;
    localparam int BIT_CRST  = 5;
    localparam int BIT_HALT  = 4;

    // clock config fields
    localparam int SRC_LSB = 4;
    localparam int PS_LSB  = 0;

    // reset values
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [1:0] RST_SRC   = 2'h0;
    localparam logic [3:0] RST_PS    = 4'h0;
    localparam logic       RST_HALT  = 1'b1;

    // largest prescale code, divide by 256
    localparam logic [3:0] PS_MAX = 4'h8;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // count source encoding
    typedef enum logic [1:0] {
        MT_SRC_BUS   = 2'h0,
        MT_SRC_FIXED = 2'h1,
        MT_SRC_EXT_F = 2'h2,
        MT_SRC_EXT_R = 2'h3
    } mt_src_t;

    // bus clock period in ns
    localparam int CLK_PERIOD_NS = 25;
endpackage : mt_pkg

// file: mt_ext_src.sv
// far-side model: timer clock pin bursts and the fixed clock
`timescale 1ns/1ps
module mt_ext_src (
    input  wire logic        aclk,    // bus clock
    input  wire logic [15:0] tog,     // pin toggles in next burst
    input  wire logic        go,      // start a burst
    output logic             busy,    // burst still running
    output logic             pin,     // timer clock pin
    output logic             fclk     // fixed clock level
);
    logic [15:0] left_q;
    logic [2:0]  ph_q;

    initial begin
        {pin, fclk, left_q, ph_q} = '0;
    end

    // pin toggles every other cycle, quarter rate; idle it stands still
    always @(posedge aclk) begin
        ph_q <= ph_q + 3'h1;
        fclk <= ph_q[2];
        if (go) begin
            left_q <= tog;
        end else if (left_q != 16'h0 && ph_q[0]) begin
            pin    <= ~pin;
            left_q <= left_q - 16'h1;
        end
    end

    assign busy = go || (left_q != 16'h0);
endmodule : mt_ext_src

// file: modulo_timer_8bit_tb.sv
// self-checking bench for the modulo timer
`timescale 1ns/1ps
module modulo_timer_8bit_tb;
    logic        aclk, aresetn, awv, wv, bready, arv, rready, irq;
    logic        awready, wready, bvalid, arready, rvalid, dwk;
    logic        go, busy, pin, fclk, lvl;
    logic [2:0]  md;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rdat;
    logic [1:0]  bresp, rresp;
    logic [15:0] tog;
    int          error_cnt, tests_run, cyc, p, m, lim, n, k;

    mt_timer dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_timer_clock_pin(pin), .fixed_freq_clock(fclk),
        .wait_mode(md[2]), .stop_mode(md[0]), .stop_deep_wake(dwk),
        .debug_active(md[1]), .irq(irq)
    );

    mt_ext_src src (
        .aclk(aclk), .tog(tog), .go(go), .busy(busy), .pin(pin), .fclk(fclk)
    );

    // clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a > mt_pkg::OFS_IRQMASK) ? mt_pkg::RESP_SLVERR
                                         : mt_pkg::RESP_OKAY;
    endfunction : resp_of

    // count after given source edges from a cleared prescaler
    function automatic int expc(input int e, ps, lm);
        return (e >> ps) % ((lm == 0) ? 256 : lm + 1);
    endfunction : expc

    // axi4-lite write: each channel released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata  <= d;
        awv    <= 1'b1;
        wv     <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(resp_of(a)), 32'(bresp));
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arv    <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arv <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rdat = rdata;
        chk("rresp", 32'(resp_of(a)), 32'(rresp));
    endtask : rd

    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        rd(a);
        chk(nm, e, rdat);
    endtask : rc

    // pin burst, then let the synchroniser and prescaler settle
    task automatic edges(input int t);
        @(posedge aclk);
        tog <= t[15:0];
        go  <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        while (busy) @(posedge aclk);
        repeat (6) @(posedge aclk);
        lvl = lvl ^ t[0];
    endtask : edges

    task automatic setup(input mt_pkg::mt_src_t s, input int ps, lm,
                         input logic [31:0] ct);
        wr(mt_pkg::OFS_CTRL, 32'h10);
        wr(mt_pkg::OFS_CLKCFG, {26'h0, s, ps[3:0]});
        wr(mt_pkg::OFS_LIMIT, 32'(lm));
        wr(mt_pkg::OFS_CTRL, ct);
    endtask : setup

    task automatic close_out();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // main sequence
    initial begin
        {aresetn, awv, wv, bready, arv, rready, go, md, dwk, lvl} = '0;
        {awaddr, araddr, wdata, tog, rdat} = '0;
        {error_cnt, tests_run, cyc} = '0;
        void'($urandom(32'h8EA7));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc("ctrl_rst", mt_pkg::OFS_CTRL, 32'h10);
        rc("cfg_rst", mt_pkg::OFS_CLKCFG, 32'h0);
        rc("lim_rst", mt_pkg::OFS_LIMIT, 32'h0);
        wr(8'h18, 32'h1);
        rc("unmapped", 8'h18, 32'h0);
        $display("[TEST] reset and map done");
        // pin edges at random prescales 0 to 5, random limits; first pass
        // uses a code from eight to fifteen, which still divides by 256
        for (int i = 0; i < 6; i++) begin
            p   = (i == 0) ? int'(mt_pkg::PS_MAX) : $urandom_range(5, 0);
            m   = $urandom_range(3, 1);
            lim = $urandom_range(40, 0);
            n   = 2 * (m << p) + 1;
            k   = lvl ? n / 2 : (n + 1) / 2;
            if (!i[0]) k = n - k;
            setup(i[0] ? mt_pkg::MT_SRC_EXT_R : mt_pkg::MT_SRC_EXT_F,
                  (i == 0) ? p + int'($urandom_range(7, 0)) : p, lim, 32'h0);
            edges(n);
            rc("count", mt_pkg::OFS_COUNT, 32'(expc(k, p, lim)));
        end
        $display("[TEST] pin source and prescale done");
        for (int s = 0; s < 2; s++) begin
            setup(mt_pkg::mt_src_t'(s), 1 - s, 0, 32'h0);
            repeat (40) @(posedge aclk);
            wr(mt_pkg::OFS_CTRL, 32'h10);
            rd(mt_pkg::OFS_COUNT);
            // bus source divided by two, fixed source by one
            k = s ? int'(rdat inside {[4:7]}) : int'(rdat inside {[18:26]});
            chk("src_rate", 32'h1, 32'(k));
        end
        $display("[TEST] bus and fixed source done");
        lim = $urandom_range(9, 1);
        setup(mt_pkg::MT_SRC_EXT_R, 0, lim, 32'h40);
        edges(2 * lim + 2);
        rc("wrap_cnt", mt_pkg::OFS_COUNT, 32'h0);
        rc("flag_set", mt_pkg::OFS_CTRL, 32'hC0);
        chk("irq_on", 32'h1, 32'(irq));
        wr(mt_pkg::OFS_CTRL, 32'h40);
        rc("flag_clr", mt_pkg::OFS_CTRL, 32'h40);
        chk("irq_off", 32'h0, 32'(irq));
        wr(mt_pkg::OFS_IRQMASK, 32'h1);
        // registered interrupt follows the mask one edge later
        @(posedge aclk);
        chk("irq_mask", 32'h1, 32'(irq));
        rc("stat_set", mt_pkg::OFS_IRQSTAT, 32'h1);
        rc("stat_clr", mt_pkg::OFS_IRQSTAT, 32'h0);
        chk("irq_clr", 32'h0, 32'(irq));
        edges(2 * lim + 2);
        wr(mt_pkg::OFS_CTRL, 32'h0);
        rc("flag_kept", mt_pkg::OFS_CTRL, 32'h80);
        wr(mt_pkg::OFS_CTRL, 32'h0);
        rc("flag_clr2", mt_pkg::OFS_CTRL, 32'h0);
        $display("[TEST] wrap flag and irq done");
        edges(2 * lim + 4);
        wr(mt_pkg::OFS_CTRL, 32'h20);
        rc("crst_ctrl", mt_pkg::OFS_CTRL, 32'h0);
        rc("crst_cnt", mt_pkg::OFS_COUNT, 32'h0);
        edges(2 * lim + 2);
        wr(mt_pkg::OFS_LIMIT, 32'(lim));
        rc("lim_clr", mt_pkg::OFS_CTRL, 32'h0);
        $display("[TEST] counter reset done");
        wr(mt_pkg::OFS_LIMIT, 32'h0);
        edges(6);
        wr(mt_pkg::OFS_CTRL, 32'h10);
        edges(6);
        rc("halt", mt_pkg::OFS_COUNT, 32'h3);
        wr(mt_pkg::OFS_CTRL, 32'h0);
        // stop, debug, then wait mode; stop and debug hold, wait counts
        for (int j = 0; j < 3; j++) begin
            md[j] <= 1'b1;
            edges(6);
            md[j] <= 1'b0;
            k = (j == 2) ? 6 : 3;
            rc("mode", mt_pkg::OFS_COUNT, 32'(k));
        end
        $display("[TEST] halt and modes done");
        dwk <= 1'b1;
        @(posedge aclk);
        dwk <= 1'b0;
        rc("wake_ctrl", mt_pkg::OFS_CTRL, 32'h10);
        rc("wake_cnt", mt_pkg::OFS_COUNT, 32'h0);
        rc("wake_cfg", mt_pkg::OFS_CLKCFG, 32'h0);
        $display("[TEST] deep wake done");
        close_out();
    end
endmodule : modulo_timer_8bit_tb
